/* oiv_otg_defines.vh */
// Register offsets, field positions and reset values of the OTG cable and bus-power status block.
`ifndef OIV_OTG_DEFINES_VH
`define OIV_OTG_DEFINES_VH

// Register byte addresses on the APB bus.
`define OIV_ADDR_CTRL 12'h000
`define OIV_ADDR_EN_RISE 12'h004
`define OIV_ADDR_EN_FALL 12'h008
`define OIV_ADDR_STATUS 12'h00c
`define OIV_ADDR_CK_EN_RISE 12'h010
`define OIV_ADDR_CK_EN_FALL 12'h014
`define OIV_ADDR_CK_STATUS 12'h018
`define OIV_ADDR_RID 12'h01c
`define OIV_ADDR_EVENT 12'h020

// Control register fields.
`define OIV_CTRL_BIAS 0
`define OIV_CTRL_USE_OUTSIDE 1
`define OIV_CTRL_PASS_THRU 2
`define OIV_CTRL_COMPLEMENT 3
`define OIV_CTRL_W 4
`define OIV_CTRL_RST 4'h0

// Interrupt status and enable fields, bus-power and ident group.
`define OIV_BIT_VBUS_VALID 1
`define OIV_BIT_SESS_VALID 2
`define OIV_BIT_SESS_END 3
`define OIV_BIT_ID_GND 4
`define OIV_EN_W 5
`define OIV_EN_RST 5'h1e

// Carkit group: floating-ident flag and its enables.
`define OIV_BIT_ID_FLOAT 0
`define OIV_CK_EN_RST 1'h0

// Event register: bits 4:0 mirror the status layout, bit 5 is the float event.
`define OIV_EVT_FLOAT 5
`define OIV_EVT_W 6

// Resistance codes reported by the ident converter.
`define OIV_RID_GROUND 3'h0
`define OIV_RID_R75 3'h1
`define OIV_RID_R102K 3'h2
`define OIV_RID_R200K 3'h3
`define OIV_RID_R440K 3'h4
`define OIV_RID_FLOAT 3'h5
`define OIV_RID_NONE 3'h7

// Bus-power state encodings carried in the receive command.
`define OIV_VBUS_BELOW_END 2'h0
`define OIV_VBUS_END_TO_VALID 2'h1
`define OIV_VBUS_SESS_VALID 2'h2
`define OIV_VBUS_VALID 2'h3

// Level of the outside bus-valid indicator input, which is tied off.
`define OIV_OUTSIDE_IND_LEVEL 1'h1

`endif

/* oiv_otg_status.v */
// OTG cable identification and bus-power status logic with APB registers.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "oiv_otg_defines.vh"

module oiv_otg_status #(
   parameter SYNC_STAGES = 2
) (
   input wire clock_i,
   input wire arst_n_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output reg pslverr_o,
   // Raw analog comparator outputs.
   input wire vbus_valid_cmp_i,
   input wire sess_valid_cmp_i,
   input wire sess_end_cmp_i,
   input wire ident_gnd_cmp_i,
   input wire ident_float_cmp_i,
   // One-hot ident resistance class: ground, 75, 102k, 200k, 440k, floating.
   input wire [5:0] rid_class_i,
   input wire sync_mode_i,
   // Analog controls.
   output reg ident_pin_bias_enable_o,
   output reg sess_end_cmp_en_o,
   output reg vbus_valid_cmp_en_o,
   // Receive command toward the ULPI side.
   output reg rxcmd_req_o,
   input wire rxcmd_ack_i,
   output reg [1:0] rxcmd_vbus_state_o,
   output reg rxcmd_alt_int_o,
   output reg rxcmd_ident_o
);

   // Register storage.
   reg [`OIV_CTRL_W-1:0] ctrl_r;
   reg [`OIV_EN_W-1:0] en_rise_r;
   reg [`OIV_EN_W-1:0] en_fall_r;
   reg ck_en_rise_r;
   reg ck_en_fall_r;
   reg [2:0] rid_r;
   reg [`OIV_EVT_W-1:0] event_r;
   reg [`OIV_EVT_W-1:0] event_nxt;

   // Synchroniser chain, one row per stage, five comparators wide.
   reg [4:0] sync_r [0:SYNC_STAGES-1];
   reg [4:0] cmp_prev_r;
   reg pend_std_r;
   reg pend_alt_r;
   reg [SYNC_STAGES:0] arm_r;

   wire [4:0] cmp_sync;
   wire [4:0] flags;
   wire [4:0] rise;
   wire [4:0] fall;
   wire [4:0] std_evt;
   wire alt_evt;
   wire sess_end_on;
   wire vbus_valid_on;
   wire outside_ind;
   wire bus_valid_src;
   wire apb_wr;
   wire apb_rd;
   wire [31:0] status_word;
   reg [2:0] rid_code;
   reg [1:0] vbus_state;
   integer i;

   // Each stage is read only by the next stage; only the last stage feeds the flag logic.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (i = 0; i < SYNC_STAGES; i = i + 1) begin
            sync_r[i] <= 5'h00;
         end
      end else begin
         sync_r[0] <= {ident_gnd_cmp_i, sess_end_cmp_i, sess_valid_cmp_i,
                       vbus_valid_cmp_i, ident_float_cmp_i};
         for (i = 1; i < SYNC_STAGES; i = i + 1) begin
            sync_r[i] <= sync_r[i-1];
         end
      end
   end

   assign cmp_sync = sync_r[SYNC_STAGES-1];

   // The session-end and bus-valid comparators count as disabled when both their edge enables are clear.
   assign sess_end_on = en_rise_r[`OIV_BIT_SESS_END] | en_fall_r[`OIV_BIT_SESS_END];
   assign vbus_valid_on = en_rise_r[`OIV_BIT_VBUS_VALID] |
                          en_fall_r[`OIV_BIT_VBUS_VALID];

   // Flags in status layout; bit 0 carries the floating flag for edge logic.
   // Session-valid is never gated, so its state stays readable when muted.
   assign flags[`OIV_BIT_ID_FLOAT] = cmp_sync[0];
   assign flags[`OIV_BIT_VBUS_VALID] = cmp_sync[1] & vbus_valid_on;
   assign flags[`OIV_BIT_SESS_VALID] = cmp_sync[2];
   assign flags[`OIV_BIT_SESS_END] = cmp_sync[3] & sess_end_on;
   assign flags[`OIV_BIT_ID_GND] = cmp_sync[4];

   // Previous flag values feed the edge detectors.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmp_prev_r <= 5'h00;
      end else begin
         cmp_prev_r <= flags;
      end
   end

   // Edges are ignored until the synchroniser and the previous-value register hold
   // real samples, so an idle pin level is not reported as a change after reset.
   // A comparator that moves within those first cycles is seen only as a level.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         arm_r <= {(SYNC_STAGES+1){1'b0}};
      end else begin
         arm_r <= {arm_r[SYNC_STAGES-1:0], 1'b1};
      end
   end

   assign rise = flags & ~cmp_prev_r & {5{arm_r[SYNC_STAGES]}};
   assign fall = ~flags & cmp_prev_r & {5{arm_r[SYNC_STAGES]}};

   // The grounded flag is watched whatever the bias bit holds: the weak pull-up
   // keeps the comparator alive, so a resistor to ground is still reported.
   assign std_evt[`OIV_BIT_ID_GND] = (rise[`OIV_BIT_ID_GND] & en_rise_r[`OIV_BIT_ID_GND]) |
                                     (fall[`OIV_BIT_ID_GND] & en_fall_r[`OIV_BIT_ID_GND]);
   assign std_evt[`OIV_BIT_SESS_END] = (rise[`OIV_BIT_SESS_END] & en_rise_r[`OIV_BIT_SESS_END]) |
                                       (fall[`OIV_BIT_SESS_END] & en_fall_r[`OIV_BIT_SESS_END]);
   assign std_evt[`OIV_BIT_SESS_VALID] =
      (rise[`OIV_BIT_SESS_VALID] & en_rise_r[`OIV_BIT_SESS_VALID]) |
      (fall[`OIV_BIT_SESS_VALID] & en_fall_r[`OIV_BIT_SESS_VALID]);
   assign std_evt[`OIV_BIT_VBUS_VALID] =
      (rise[`OIV_BIT_VBUS_VALID] & en_rise_r[`OIV_BIT_VBUS_VALID]) |
      (fall[`OIV_BIT_VBUS_VALID] & en_fall_r[`OIV_BIT_VBUS_VALID]);
   assign std_evt[0] = 1'b0;

   // Floating-flag changes use the carkit enables and go out as alternate interrupts.
   assign alt_evt = (rise[`OIV_BIT_ID_FLOAT] & ck_en_rise_r) |
                    (fall[`OIV_BIT_ID_FLOAT] & ck_en_fall_r);

   // The outside indicator has no pin; it is a constant high level.
   assign outside_ind = `OIV_OUTSIDE_IND_LEVEL;

   // Source of the bus-valid level carried by the receive command.
   assign bus_valid_src = !ctrl_r[`OIV_CTRL_USE_OUTSIDE] ? flags[`OIV_BIT_VBUS_VALID] :
                          ctrl_r[`OIV_CTRL_PASS_THRU] ?
                          (outside_ind ^ ctrl_r[`OIV_CTRL_COMPLEMENT]) :
                          (flags[`OIV_BIT_VBUS_VALID] &
                           (outside_ind ^ ctrl_r[`OIV_CTRL_COMPLEMENT]));

   // Bus-power state ladder, highest threshold first.
   always @* begin
      if (bus_valid_src) begin
         vbus_state = `OIV_VBUS_VALID;
      end else if (flags[`OIV_BIT_SESS_VALID]) begin
         vbus_state = `OIV_VBUS_SESS_VALID;
      end else if (!flags[`OIV_BIT_SESS_END]) begin
         vbus_state = `OIV_VBUS_END_TO_VALID;
      end else begin
         vbus_state = `OIV_VBUS_BELOW_END;
      end
   end

   // Command data track the live state; a pending request is held until acknowledged,
   // and a new event in the acknowledge cycle keeps the request standing.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_std_r <= 1'b0;
         pend_alt_r <= 1'b0;
         rxcmd_req_o <= 1'b0;
         rxcmd_vbus_state_o <= `OIV_VBUS_BELOW_END;
         rxcmd_alt_int_o <= 1'b0;
         rxcmd_ident_o <= 1'b0;
      end else begin
         pend_std_r <= (|std_evt) | (pend_std_r & ~(rxcmd_req_o & rxcmd_ack_i));
         pend_alt_r <= alt_evt | (pend_alt_r & ~(rxcmd_req_o & rxcmd_ack_i));
         rxcmd_req_o <= (|std_evt) | alt_evt |
                        ((pend_std_r | pend_alt_r) & ~(rxcmd_req_o & rxcmd_ack_i));
         rxcmd_alt_int_o <= alt_evt | (pend_alt_r & ~(rxcmd_req_o & rxcmd_ack_i));
         rxcmd_vbus_state_o <= vbus_state;
         rxcmd_ident_o <= flags[`OIV_BIT_ID_GND];
      end
   end

   // Resistance class to code; an empty or ambiguous class reports no reading.
   always @* begin
      case (rid_class_i)
         6'h01: rid_code = `OIV_RID_GROUND;
         6'h02: rid_code = `OIV_RID_R75;
         6'h04: rid_code = `OIV_RID_R102K;
         6'h08: rid_code = `OIV_RID_R200K;
         6'h10: rid_code = `OIV_RID_R440K;
         6'h20: rid_code = `OIV_RID_FLOAT;
         default: rid_code = `OIV_RID_NONE;
      endcase
   end

   // The code is refreshed only in synchronous mode and held otherwise.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rid_r <= `OIV_RID_NONE;
      end else if (sync_mode_i) begin
         rid_r <= rid_code;
      end
   end

   // APB decode; the slave answers in the first access cycle.
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign apb_rd = psel_i & penable_i & ~pwrite_i;
   assign pready_o = 1'b1;

   assign status_word = {27'h0, flags[`OIV_BIT_ID_GND], flags[`OIV_BIT_SESS_END],
                         flags[`OIV_BIT_SESS_VALID], flags[`OIV_BIT_VBUS_VALID],
                         1'b0};

   // Writable registers; enables default so that every comparator but the floating one runs.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r <= `OIV_CTRL_RST;
         en_rise_r <= `OIV_EN_RST;
         en_fall_r <= `OIV_EN_RST;
         ck_en_rise_r <= `OIV_CK_EN_RST;
         ck_en_fall_r <= `OIV_CK_EN_RST;
      end else if (apb_wr) begin
         if (paddr_i == `OIV_ADDR_CTRL) begin
            ctrl_r <= pwdata_i[`OIV_CTRL_W-1:0];
         end else if (paddr_i == `OIV_ADDR_EN_RISE) begin
            en_rise_r <= {pwdata_i[`OIV_EN_W-1:1], 1'b0};
         end else if (paddr_i == `OIV_ADDR_EN_FALL) begin
            en_fall_r <= {pwdata_i[`OIV_EN_W-1:1], 1'b0};
         end else if (paddr_i == `OIV_ADDR_CK_EN_RISE) begin
            ck_en_rise_r <= pwdata_i[`OIV_BIT_ID_FLOAT];
         end else if (paddr_i == `OIV_ADDR_CK_EN_FALL) begin
            ck_en_fall_r <= pwdata_i[`OIV_BIT_ID_FLOAT];
         end
      end
   end

   // Sticky event record; a write of one clears, but a new event wins the same cycle.
   always @* begin
      event_nxt = event_r;
      if (apb_wr && paddr_i == `OIV_ADDR_EVENT) begin
         event_nxt = event_r & ~pwdata_i[`OIV_EVT_W-1:0];
      end
      event_nxt = event_nxt | {alt_evt, std_evt};
   end

   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         event_r <= 6'h00;
      end else begin
         event_r <= event_nxt;
      end
   end

   // Read mux and error answer for unmapped addresses.
   always @* begin
      prdata_o = 32'h0;
      pslverr_o = 1'b0;
      if (paddr_i == `OIV_ADDR_CTRL) begin
         prdata_o = {28'h0, ctrl_r};
      end else if (paddr_i == `OIV_ADDR_EN_RISE) begin
         prdata_o = {27'h0, en_rise_r};
      end else if (paddr_i == `OIV_ADDR_EN_FALL) begin
         prdata_o = {27'h0, en_fall_r};
      end else if (paddr_i == `OIV_ADDR_STATUS) begin
         prdata_o = status_word;
      end else if (paddr_i == `OIV_ADDR_CK_EN_RISE) begin
         prdata_o = {31'h0, ck_en_rise_r};
      end else if (paddr_i == `OIV_ADDR_CK_EN_FALL) begin
         prdata_o = {31'h0, ck_en_fall_r};
      end else if (paddr_i == `OIV_ADDR_CK_STATUS) begin
         prdata_o = {31'h0, flags[`OIV_BIT_ID_FLOAT]};
      end else if (paddr_i == `OIV_ADDR_RID) begin
         prdata_o = {29'h0, rid_r};
      end else if (paddr_i == `OIV_ADDR_EVENT) begin
         prdata_o = {26'h0, event_r};
      end else begin
         pslverr_o = psel_i & penable_i;
      end
      if (!apb_rd) begin
         prdata_o = 32'h0;
      end
   end

   // Analog controls. The strong pull-up stays on while float detection is wanted,
   // and drops out to save current once bias and both float enables are clear.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ident_pin_bias_enable_o <= 1'b0;
         sess_end_cmp_en_o <= 1'b0;
         vbus_valid_cmp_en_o <= 1'b0;
      end else begin
         ident_pin_bias_enable_o <= ctrl_r[`OIV_CTRL_BIAS] | ck_en_rise_r |
                                    ck_en_fall_r;
         sess_end_cmp_en_o <= sess_end_on;
         vbus_valid_cmp_en_o <= vbus_valid_on;
      end
   end

endmodule

/* oiv_otg_status_asserts.sv */
// Port-level assertions for the OTG cable and bus-power status block.
`timescale 1ns/1ns
module oiv_otg_status_asserts #(
   parameter SYNC_STAGES = 2
) (
   input wire clock_i,
   input wire arst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire sess_valid_cmp_i,
   input wire ident_gnd_cmp_i,
   input wire ident_float_cmp_i,
   input wire sess_end_cmp_en_o,
   input wire vbus_valid_cmp_en_o,
   input wire rxcmd_req_o,
   input wire rxcmd_ack_i,
   input wire rxcmd_alt_int_o,
   input wire rxcmd_ident_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   logic [1:0] up_r;
   wire rd_w = psel_i && penable_i && !pwrite_i && up_r == 2'h3;
   wire st_w = rd_w && paddr_i == 12'h00c;
   // Counts the first edges after reset, while the sync stages still hold reset values.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   gnd_status_a: assert property (
      st_w && $stable(ident_gnd_cmp_i) && $past(ident_gnd_cmp_i, 2) == ident_gnd_cmp_i
      |-> prdata_o[4] == ident_gnd_cmp_i) else $error("grounded flag misread");
   float_status_a: assert property (
      rd_w && paddr_i == 12'h018 && $stable(ident_float_cmp_i)
      && $past(ident_float_cmp_i, 2) == ident_float_cmp_i
      |-> prdata_o[0] == ident_float_cmp_i) else $error("floating flag misread");
   sess_valid_a: assert property (
      st_w && $stable(sess_valid_cmp_i) && $past(sess_valid_cmp_i, 2) == sess_valid_cmp_i
      |-> prdata_o[2] == sess_valid_cmp_i) else $error("session-valid flag misread");
   sess_end_off_a: assert property (
      st_w && !sess_end_cmp_en_o ##1 !sess_end_cmp_en_o |-> !$past(prdata_o[3]))
      else $error("session-end flag set while disabled");
   vbus_off_a: assert property (
      st_w && !vbus_valid_cmp_en_o ##1 !vbus_valid_cmp_en_o |-> !$past(prdata_o[1]))
      else $error("bus-valid flag set while disabled");
   req_hold_a: assert property (
      rxcmd_req_o && !rxcmd_ack_i |=> rxcmd_req_o) else $error("command dropped unacked");
   alt_with_req_a: assert property (
      rxcmd_alt_int_o |-> rxcmd_req_o) else $error("alternate bit without command");
   ident_track_a: assert property (
      (up_r == 2'h3 && $stable(ident_gnd_cmp_i)) [*4] |-> rxcmd_ident_o == ident_gnd_cmp_i)
      else $error("command ident bit stale");
endmodule
bind oiv_otg_status oiv_otg_status_asserts #(.SYNC_STAGES(SYNC_STAGES)) oiv_otg_status_asserts_inst (
   .clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
   .sess_valid_cmp_i, .ident_gnd_cmp_i, .ident_float_cmp_i, .sess_end_cmp_en_o,
   .vbus_valid_cmp_en_o, .rxcmd_req_o, .rxcmd_ack_i, .rxcmd_alt_int_o, .rxcmd_ident_o);

/* oiv_link_model.sv */
// Behavioural link controller that takes receive commands after a set delay.
`timescale 1ns/1ns
module oiv_link_model (
   input wire clock_i,
   input wire arst_n_i,
   input wire rxcmd_req_i,
   input wire rxcmd_alt_int_i,
   input wire [3:0] delay_i,
   output logic rxcmd_ack_o,
   output logic [7:0] n_cmd_o,
   output logic [7:0] n_alt_o
);
   logic [3:0] wait_r;
   // Acknowledges after delay_i cycles, so a slow link tests that commands are held.
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rxcmd_ack_o <= 1'b0;
         wait_r <= 4'h0;
         n_cmd_o <= 8'h0;
         n_alt_o <= 8'h0;
      end else begin
         if (rxcmd_req_i && rxcmd_ack_o) begin
            n_cmd_o <= n_cmd_o + 8'h1;
            n_alt_o <= n_alt_o + {7'h0, rxcmd_alt_int_i};
         end
         if (rxcmd_ack_o) begin
            rxcmd_ack_o <= 1'b0;
            wait_r <= 4'h0;
         end else if (rxcmd_req_i && wait_r >= delay_i) begin
            rxcmd_ack_o <= 1'b1;
         end else if (rxcmd_req_i) begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule

/* oiv_otg_status_tb.sv */
// Self-checking bench for the OTG cable and bus-power status block.
`timescale 1ns/1ns
`include "oiv_otg_defines.vh"
module oiv_otg_status_tb;
   localparam int BIAS_WAIT = 50; // Shortened settle wait before sampling the ident pin.
   logic clock_i, arst_n_i, psel, penable, pwrite, ack, smode, vbus, sessv, send, gnd, flt;
   logic pready, pslverr, bias, send_en, vbus_en, req, alt, ident;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] rid;
   logic [1:0] vstate;
   logic [3:0] dly;
   logic [7:0] n_cmd, n_alt, c0;
   logic [65:0] note_q[$];
   int n_mismatch, checks;
   oiv_otg_status #(.SYNC_STAGES(2)) oiv_otg_status_inst (
      .clock_i, .arst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .vbus_valid_cmp_i(vbus), .sess_valid_cmp_i(sessv),
      .sess_end_cmp_i(send), .ident_gnd_cmp_i(gnd), .ident_float_cmp_i(flt),
      .rid_class_i(rid), .sync_mode_i(smode), .ident_pin_bias_enable_o(bias),
      .sess_end_cmp_en_o(send_en), .vbus_valid_cmp_en_o(vbus_en), .rxcmd_req_o(req),
      .rxcmd_ack_i(ack), .rxcmd_vbus_state_o(vstate), .rxcmd_alt_int_o(alt),
      .rxcmd_ident_o(ident));
   oiv_link_model oiv_link_model_inst (
      .clock_i, .arst_n_i, .rxcmd_req_i(req), .rxcmd_alt_int_i(alt), .delay_i(dly),
      .rxcmd_ack_o(ack), .n_cmd_o(n_cmd), .n_alt_o(n_alt));
   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      checks++;
      if (got !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: port value %0h expected %0h", $time, got, e);
      end
   endtask
   // One APB transfer with an idle edge after it; a read notes {mask, answer} for the monitor.
   task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d,
      input logic [32:0] m);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d[31:0];
      if (!w) note_q.push_back({m, d});
      @(posedge clock_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) chk(8'h0, 8'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask
   // Takes the oldest note whenever a read completes and compares error flag and data.
   always @(posedge clock_i) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         checks++;
         if (note_q.size() == 0 || ({pslverr, prdata} & note_q[0][65:33]) !== note_q[0][32:0])
         begin
            n_mismatch++;
            $display("mismatch at %0t: read of %0h", $time, paddr);
         end
         if (note_q.size() != 0) void'(note_q.pop_front());
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   // A hang anywhere counts as a mismatch and closes the run.
   initial begin
      repeat (100000) @(posedge clock_i);
      chk(8'h0, 8'h1);
      print_verdict();
   end
   initial begin
      {arst_n_i, psel, penable, pwrite, smode, vbus, sessv, send} = '0;
      {gnd, flt, paddr, pwdata, rid, dly, n_mismatch, checks} = {2'h3, 44'h0, 6'h20, 4'h0, 64'h0};
      void'($urandom(32'hd5d6));
      repeat (5) @(posedge clock_i);
      arst_n_i <= 1'b1;
      @(posedge clock_i);
      apb(0, `OIV_ADDR_CTRL, 33'h0, 33'hf);
      apb(0, `OIV_ADDR_EN_FALL, 33'h1e, 33'h1f);
      apb(0, `OIV_ADDR_CK_EN_RISE, 33'h0, 33'h1);
      apb(0, `OIV_ADDR_RID, 33'h7, 33'h7);
      apb(0, 12'h040, 33'h1_0000_0000, '1);
      $display("test reset values done");
      smode <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rid <= 6'h1 << i;
         gnd <= (i == 2 || i == 5);
         flt <= (i == 5);
         repeat (4) @(posedge clock_i);
         apb(0, `OIV_ADDR_RID, 33'(i), 33'h7);
         apb(0, `OIV_ADDR_STATUS, {28'h0, gnd, 4'h0}, 33'h10);
         apb(0, `OIV_ADDR_CK_STATUS, {32'h0, flt}, 33'h1);
      end
      smode <= 1'b0;
      rid <= 6'h1;
      repeat (4) @(posedge clock_i);
      apb(0, `OIV_ADDR_RID, 33'h5, 33'h7);
      $display("test ident codes done");
      apb(1, `OIV_ADDR_CTRL, 33'h1, 33'h0);
      // Registered outputs follow a write by one edge, so they are looked at one edge later.
      @(posedge clock_i);
      chk(bias, 1);
      repeat (BIAS_WAIT) @(posedge clock_i);
      apb(0, `OIV_ADDR_STATUS, 33'h10, 33'h10);
      apb(1, `OIV_ADDR_CTRL, 33'h0, 33'h0);
      @(posedge clock_i);
      chk(bias, 0);
      c0 = n_cmd;
      gnd <= 1'b0;
      repeat (16) @(posedge clock_i);
      chk(n_cmd, c0 + 8'h1);
      chk(ident, 0);
      apb(1, `OIV_ADDR_EN_RISE, 33'he, 33'h0);
      apb(1, `OIV_ADDR_EN_FALL, 33'he, 33'h0);
      c0 = n_cmd;
      gnd <= 1'b1;
      repeat (16) @(posedge clock_i);
      chk(n_cmd, c0);
      apb(1, `OIV_ADDR_EN_RISE, 33'h1e, 33'h0);
      apb(1, `OIV_ADDR_EN_FALL, 33'h1e, 33'h0);
      $display("test grounded events done");
      apb(1, `OIV_ADDR_CK_EN_RISE, 33'h1, 33'h0);
      apb(1, `OIV_ADDR_CK_EN_FALL, 33'h1, 33'h0);
      for (int j = 0; j < 3; j++) begin
         if (j == 2) apb(1, `OIV_ADDR_CK_EN_RISE, 33'h0, 33'h0);
         if (j == 2) apb(1, `OIV_ADDR_CK_EN_FALL, 33'h0, 33'h0);
         dly <= 4'($urandom_range(7, 0));
         c0 = n_alt;
         flt <= ~flt;
         repeat (16) @(posedge clock_i);
         chk(n_alt, c0 + 8'(j < 2));
      end
      $display("test float events done");
      for (int j = 0; j < 6; j++) begin
         {vbus, sessv, send} <= 3'($urandom);
         repeat (4) @(posedge clock_i);
         apb(0, `OIV_ADDR_STATUS, {29'h0, send, sessv, vbus, 1'b0}, 33'he);
      end
      {vbus, sessv, send} <= 3'h6;
      apb(1, `OIV_ADDR_CTRL, 33'hc, 33'h0);
      repeat (4) @(posedge clock_i);
      chk(vstate, `OIV_VBUS_VALID);
      apb(1, `OIV_ADDR_CTRL, 33'he, 33'h0);
      @(posedge clock_i);
      chk(vstate, `OIV_VBUS_SESS_VALID);
      vbus <= 1'b0;
      apb(1, `OIV_ADDR_CTRL, 33'h6, 33'h0);
      @(posedge clock_i);
      chk(vstate, `OIV_VBUS_VALID);
      // Without pass-through the outside level only qualifies the internal comparator, now low.
      apb(1, `OIV_ADDR_CTRL, 33'h2, 33'h0);
      @(posedge clock_i);
      chk(vstate, `OIV_VBUS_SESS_VALID);
      $display("test bus-valid source done");
      {vbus, sessv, send} <= 3'h7;
      apb(1, `OIV_ADDR_EN_RISE, 33'h14, 33'h0);
      apb(1, `OIV_ADDR_EN_FALL, 33'h14, 33'h0);
      @(posedge clock_i);
      chk({send_en, vbus_en}, 0);
      apb(0, `OIV_ADDR_STATUS, 33'h4, 33'he);
      apb(1, `OIV_ADDR_EN_RISE, 33'h10, 33'h0);
      apb(1, `OIV_ADDR_EN_FALL, 33'h10, 33'h0);
      c0 = n_cmd;
      sessv <= 1'b0;
      repeat (16) @(posedge clock_i);
      chk(n_cmd, c0);
      apb(0, `OIV_ADDR_STATUS, 33'h0, 33'h4);
      $display("test comparator enables done");
      chk(8'(note_q.size()), 0);
      print_verdict();
   end
endmodule
